// file: hw/ssc_config_regs.sv
`timescale 1ns/1ps
module ssc_config_regs
  import ssc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic seq_reset_n,
  input wire logic spi_enable,
  input wire logic spi_clk,
  input wire logic spi_data_in,
  output logic spi_data_out,
  output logic spi_data_oe,
  output logic seq_clk,
  output logic [2:0] int_time_oe,
  output logic master_mode,
  output logic subsample_y,
  output logic [1:0] clk_range,
  output logic analog_out_on,
  output logic line_calib,
  output logic second_slope_on,
  output logic third_slope_on,
  output logic reverse_x,
  output logic reverse_y,
  output logic nondestructive,
  output logic [7:0] column_start,
  output logic [8:0] row_start,
  output logic [7:0] kernel_count,
  output logic [11:0] reset_pulse_lines,
  output logic [11:0] dual_slope_position,
  output logic [11:0] triple_slope_position,
  output logic [11:0] transfer_position,
  output logic [7:0] calibration_level_code,
  output logic [7:0] black_level_code,
  output logic [7:0] offset_level_code,
  output logic [11:0] converter_path_select,
  output logic [11:0] amplifier_settings,
  output logic [32:0] converter_trim
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_HEAD = 4'b0010,
    ST_WR = 4'b0100,
    ST_RD = 4'b1000
  } ssc_state_e;

  ssc_state_e state_reg;
  logic [SSC_CNT_W-1:0] bit_cnt_reg;
  logic [16:0] shift_reg;
  logic [SSC_ADDR_W-1:0] addr_reg;
  logic [SSC_DATA_W-1:0] rd_shift_reg;
  logic [1:0] div_reg;
  logic spi_clk_q;
  logic seq_rst_n_q;
  logic [SSC_DATA_W-1:0] cfg_mem [SSC_NUM_REGS];
  logic [SSC_NUM_REGS-1:0] at_default;
  logic sclk_rise;
  logic sclk_fall;
  logic seq_rst_enter;
  logic head_done;
  logic [SSC_ADDR_W-1:0] head_addr;
  logic commit;
  logic wr_ok;
  logic [SSC_DATA_W-1:0] wr_word;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // --------------------------------------------------------------------------
  // sequencer clock divider
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_reg <= 2'h0;
    end else begin
      div_reg <= 2'(div_reg + SSC_SEQ_DIV_STEP);
    end
  end

  assign seq_clk = div_reg[1];

  AST_SEQ_CLK_DIV4: assert property ($rose(seq_clk) |-> ##4 $rose(seq_clk))
    else $error("sequencer clock is not the input clock over four");

  // --------------------------------------------------------------------------
  // pin sampling and edge detection
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      spi_clk_q <= 1'b0;
      seq_rst_n_q <= 1'b1;
    end else begin
      spi_clk_q <= spi_clk;
      seq_rst_n_q <= seq_reset_n;
    end
  end

  assign sclk_rise = spi_clk & ~spi_clk_q;
  assign sclk_fall = ~spi_clk & spi_clk_q;
  // only the falling edge of the sequencer reset restores the registers,
  // so writes made while it is held low still land
  assign seq_rst_enter = seq_rst_n_q & ~seq_reset_n;

  // --------------------------------------------------------------------------
  // serial frame receiver
  // --------------------------------------------------------------------------
  assign head_done = (state_reg == ST_HEAD) && spi_enable && sclk_rise &&
                     (bit_cnt_reg == SSC_HEAD_LAST);
  assign head_addr = {shift_reg[2:0], spi_data_in};
  // a write needs exactly the full frame; short or long frames are dropped
  assign commit = (state_reg == ST_WR) && !spi_enable &&
                  (bit_cnt_reg == SSC_FRAME_LEN);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 5'h00;
      shift_reg <= 17'h00000;
      addr_reg <= 4'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (spi_enable) begin
            state_reg <= ST_HEAD;
            bit_cnt_reg <= 5'h00;
          end
        end
        ST_HEAD: begin
          if (!spi_enable) begin
            state_reg <= ST_IDLE;
          end else if (sclk_rise) begin
            shift_reg <= {shift_reg[15:0], spi_data_in};
            bit_cnt_reg <= 5'(bit_cnt_reg + 5'h01);
            if (bit_cnt_reg == SSC_HEAD_LAST) begin
              addr_reg <= head_addr;
              state_reg <= shift_reg[3] ? ST_WR : ST_RD;
            end
          end
        end
        ST_WR: begin
          if (!spi_enable) begin
            state_reg <= ST_IDLE;
          end else if (sclk_rise) begin
            shift_reg <= {shift_reg[15:0], spi_data_in};
            if (bit_cnt_reg != SSC_CNT_SAT) begin
              bit_cnt_reg <= 5'(bit_cnt_reg + 5'h01);
            end
          end
        end
        ST_RD: begin
          if (!spi_enable) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // serial readback driver
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_shift_reg <= 12'h000;
      spi_data_out <= 1'b0;
      spi_data_oe <= 1'b0;
    end else if (head_done && !shift_reg[3]) begin
      rd_shift_reg <= cfg_mem[head_addr];
      spi_data_oe <= 1'b1;
    end else if (state_reg != ST_RD || !spi_enable) begin
      spi_data_out <= 1'b0;
      spi_data_oe <= 1'b0;
    end else if (sclk_fall) begin
      spi_data_out <= rd_shift_reg[11];
      rd_shift_reg <= {rd_shift_reg[10:0], 1'b0};
    end
  end

  AST_OE_DROPS: assert property ($fell(spi_enable) |=> !spi_data_oe)
    else $error("data pin still driven after enable fell");

  // --------------------------------------------------------------------------
  // write qualification
  // --------------------------------------------------------------------------
  always_comb begin
    wr_word = shift_reg[11:0] & SSC_REG_MASK[addr_reg];
    wr_ok = 1'b1;
    // master select and clock range keep their value outside sequencer reset
    if (addr_reg == SSC_ADDR_TIMING && seq_reset_n) begin
      wr_word = (wr_word & ~SSC_TC_RESET_ONLY) |
                (cfg_mem[0] & SSC_TC_RESET_ONLY);
    end
    // only 80 eight-pixel groups exist; out-of-range starts are refused
    if (addr_reg == SSC_ADDR_COLUMN && wr_word[7:0] > SSC_COL_START_MAX) begin
      wr_ok = 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // register storage
  // --------------------------------------------------------------------------
  generate
    for (genvar i = 0; i < SSC_NUM_REGS; i++) begin : g_reg
      always_ff @(posedge clk_sys) begin
        if (rst || seq_rst_enter) begin
          cfg_mem[i] <= SSC_RESET_VAL[i];
        end else if (commit && wr_ok && addr_reg == 4'(i)) begin
          cfg_mem[i] <= wr_word;
        end
      end
      assign at_default[i] = (cfg_mem[i] == SSC_RESET_VAL[i]);
    end
  endgenerate

  // --------------------------------------------------------------------------
  // field outputs
  // --------------------------------------------------------------------------
  assign master_mode = cfg_mem[0][SSC_TC_MASTER];
  assign int_time_oe = {3{cfg_mem[0][SSC_TC_MASTER]}};
  assign subsample_y = cfg_mem[0][SSC_TC_SUBSAMPLE];
  assign clk_range = cfg_mem[0][SSC_TC_RANGE_LSB +: 2];
  assign analog_out_on = cfg_mem[0][SSC_TC_ANALOG_OUT];
  assign line_calib = cfg_mem[0][SSC_TC_LINE_CAL];
  assign second_slope_on = cfg_mem[0][SSC_TC_SLOPE2];
  assign third_slope_on = cfg_mem[0][SSC_TC_SLOPE3];
  assign reverse_x = cfg_mem[0][SSC_TC_REV_X];
  assign reverse_y = cfg_mem[0][SSC_TC_REV_Y];
  assign nondestructive = cfg_mem[0][SSC_TC_NONDESTR];
  assign column_start = cfg_mem[1][7:0];
  assign row_start = cfg_mem[2][8:0];
  assign kernel_count = cfg_mem[3][7:0];
  assign reset_pulse_lines = cfg_mem[4];
  assign dual_slope_position = cfg_mem[5];
  assign triple_slope_position = cfg_mem[6];
  assign transfer_position = cfg_mem[7];
  assign calibration_level_code = cfg_mem[8][7:0];
  assign black_level_code = cfg_mem[9][7:0];
  assign offset_level_code = cfg_mem[10][7:0];
  assign converter_path_select = cfg_mem[11];
  assign amplifier_settings = cfg_mem[12];
  assign converter_trim = {cfg_mem[15][8:0], cfg_mem[14], cfg_mem[13]};

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  logic [SSC_ADDR_W-1:0] chk_addr_q;
  logic [SSC_DATA_W-1:0] chk_word_q;
  logic chk_wr_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      chk_addr_q <= 4'h0;
      chk_word_q <= 12'h000;
      chk_wr_q <= 1'b0;
    end else begin
      chk_addr_q <= addr_reg;
      chk_word_q <= wr_word;
      chk_wr_q <= commit && wr_ok && !seq_rst_enter;
    end
  end

  AST_RESET_DEFAULTS: assert property ($fell(rst) |-> &at_default)
    else $error("register not at reset value after reset");

  AST_SEQ_RESET_RESTORE: assert property (
    $fell(seq_reset_n) |=> &at_default)
    else $error("sequencer reset did not restore the registers");

  AST_WRITE_LANDS: assert property (chk_wr_q |->
    cfg_mem[chk_addr_q] == chk_word_q)
    else $error("accepted write did not land in its register");

  AST_MASTER_GATED: assert property (
    $changed(master_mode) |-> !$past(seq_reset_n))
    else $error("master select changed outside sequencer reset");

  AST_RANGE_GATED: assert property (
    $changed(clk_range) |-> !$past(seq_reset_n))
    else $error("clock range changed outside sequencer reset");

  AST_COLUMN_LIMIT: assert property (column_start <= SSC_COL_START_MAX)
    else $error("column start beyond last group");

  AST_TIMING_FIELDS: assert property (
    commit && addr_reg == SSC_ADDR_TIMING && seq_rst_n_q && seq_reset_n |=>
    {nondestructive, reverse_y, reverse_x, third_slope_on, second_slope_on,
     line_calib, analog_out_on, subsample_y} ==
    $past({shift_reg[10:4], shift_reg[1]}))
    else $error("timing field not at its packed position");

  AST_TRIM_HIGH: assert property (
    commit && addr_reg == SSC_ADDR_TRIM_HIGH && seq_rst_n_q && seq_reset_n |=>
    converter_trim[32:24] == $past(shift_reg[8:0]))
    else $error("trim high part not at bits 32 to 24");

  // --------------------------------------------------------------------------
  // output and readback checks
  // --------------------------------------------------------------------------
  // slave mode must release all three timing pins together,
  // otherwise the pins would fight the external timing source
  AST_INT_TIME_MIRROR: assert property (int_time_oe == {3{master_mode}})
    else $error("timing pin enables do not follow master select");

  // converters need an even duty cycle: two high, two low
  // a divider that skips a state would still pass the period check
  AST_SEQ_CLK_HIGH: assert property ($rose(seq_clk) |=> seq_clk ##1 !seq_clk)
    else $error("sequencer clock high phase is not two cycles");

  // a refused start position must leave the old window intact,
  // a half-applied value would point past the last column group
  AST_COLUMN_KEPT: assert property (
    commit && !wr_ok && !seq_rst_enter |=> $stable(column_start))
    else $error("refused column start still changed the register");

  // a frame cut short or run long carries no trustworthy data,
  // so the addressed register keeps its value
  AST_SHORT_DROPPED: assert property (
    state_reg == ST_WR && !spi_enable && bit_cnt_reg != SSC_FRAME_LEN &&
    !seq_rst_enter |=> cfg_mem[$past(addr_reg)] == $past(cfg_mem[addr_reg]))
    else $error("frame of wrong length changed a register");

  // the pin turns round right after the address, before the first
  // falling serial clock, so the controller never samples a floating line
  AST_OE_AFTER_HEAD: assert property (
    head_done && !shift_reg[3] |=> spi_data_oe)
    else $error("data pin not driven after read address");

  // each falling serial clock presents the next bit, msb first
  AST_READ_BIT: assert property (
    state_reg == ST_RD && spi_enable && sclk_fall |=>
    spi_data_out == $past(rd_shift_reg[11]))
    else $error("readback bit out of order");

  // an idle port must never drive the shared data line
  AST_IDLE_QUIET: assert property (state_reg == ST_IDLE |-> !spi_data_oe)
    else $error("data pin driven while the port is idle");

  // readout mode may only move by a write or a sequencer reset,
  // a spurious flip mid-frame would corrupt the stored pixel levels
  AST_NONDESTR_WRITTEN: assert property (
    $changed(nondestructive) |-> $past(commit || seq_rst_enter))
    else $error("non-destructive bit changed without a write");

  COV_WRITE: cover property (commit && wr_ok);
  COV_READ_BIT: cover property (state_reg == ST_RD && sclk_fall);
  COV_SEQ_RESET: cover property (seq_rst_enter);
  COV_COL_REFUSED: cover property (commit && !wr_ok);
  COV_MASTER_MOVED: cover property ($changed(master_mode));

endmodule // ssc_config_regs

// file: hw/ssc_pkg.sv
// ----------------------------------------------------------------------------
// Overview of operation
// - sequencer clock is the input clock divided by four, shared with converters
// - timing control register is 11 bits, resetting to 00000101001
// - master select one means internal integration timing, zero means slave
// - calibration bit one recalibrates each line, zero once per frame
// - second and third slope bits each enable their extra reset pulse
// - separate bits reverse horizontal and vertical readout order
// - 8-bit column start at address 1, 9-bit row start at 2, both zero
// - 8-bit kernel count at address 3, resetting to 10100000
// - 12-bit reset pulse length in lines at address 4, reset value 2
// - 12-bit dual and triple slope positions at addresses 5 and 6, zero
// - 12-bit frame transfer position at address 7, resetting to 000111100001
// - converter codes at addresses 8, 9, 10 reset to 4A, 6B, 55 hex
// - address 11 holds test path, normal path and bypass nibbles, reset 0F0
// - address 12 holds gain, unity, half gain, input, standby, fast; reset FB0
// - 33-bit trim word split over addresses 13, 14, 15 low to high
// - one timing bit selects vertical subsampling when one
// - clock range codes 11, 10, 01, 00 from fastest to slowest, default 10
// - column start counts eight-pixel groups, positions 0 to 79
// ----------------------------------------------------------------------------
package ssc_pkg;

  localparam int SSC_NUM_REGS = 16;
  localparam int SSC_ADDR_W = 4;
  localparam int SSC_DATA_W = 12;
  localparam int SSC_CNT_W = 5;

  // serial frame: 1 command bit, 4 address bits, 12 data bits
  localparam logic [4:0] SSC_HEAD_LAST = 5'h04;
  localparam logic [4:0] SSC_FRAME_LEN = 5'h11;
  localparam logic [4:0] SSC_CNT_SAT = 5'h1F;

  localparam logic [1:0] SSC_SEQ_DIV_STEP = 2'h1;

  localparam logic [3:0] SSC_ADDR_TIMING = 4'h0;
  localparam logic [3:0] SSC_ADDR_COLUMN = 4'h1;
  localparam logic [3:0] SSC_ADDR_TRIM_HIGH = 4'hF;

  localparam int SSC_TC_MASTER = 0;
  localparam int SSC_TC_SUBSAMPLE = 1;
  localparam int SSC_TC_RANGE_LSB = 2;
  localparam int SSC_TC_ANALOG_OUT = 4;
  localparam int SSC_TC_LINE_CAL = 5;
  localparam int SSC_TC_SLOPE2 = 6;
  localparam int SSC_TC_SLOPE3 = 7;
  localparam int SSC_TC_REV_X = 8;
  localparam int SSC_TC_REV_Y = 9;
  localparam int SSC_TC_NONDESTR = 10;
  localparam logic [11:0] SSC_TC_RESET_ONLY = 12'h00D;

  localparam logic [1:0] SSC_RANGE_ABOVE_80 = 2'h3;
  localparam logic [1:0] SSC_RANGE_40_80 = 2'h2;
  localparam logic [1:0] SSC_RANGE_20_40 = 2'h1;
  localparam logic [1:0] SSC_RANGE_BELOW_20 = 2'h0;

  localparam logic [7:0] SSC_COL_START_MAX = 8'h4F;

  localparam logic [11:0] SSC_RESET_VAL [SSC_NUM_REGS] = '{
    12'h029, 12'h000, 12'h000, 12'h0A0, 12'h002, 12'h000, 12'h000, 12'h1E1,
    12'h04A, 12'h06B, 12'h055, 12'h0F0, 12'hFB0, 12'hADF, 12'h6DB, 12'h0DB
  };

  localparam logic [11:0] SSC_REG_MASK [SSC_NUM_REGS] = '{
    12'h7FF, 12'h0FF, 12'h1FF, 12'h0FF, 12'hFFF, 12'hFFF, 12'hFFF, 12'hFFF,
    12'h0FF, 12'h0FF, 12'h0FF, 12'hFFF, 12'hFFF, 12'hFFF, 12'hFFF, 12'h1FF
  };

endpackage

// file: verification/ssc_ctl_model.sv
`timescale 1ns/1ps
module ssc_ctl_model (
  input wire logic clk_sys,
  input wire logic spi_data_out,
  input wire logic spi_data_oe,
  output logic spi_enable,
  output logic spi_clk,
  output logic spi_data_in
);
  logic drive_on;
  logic drive_bit;
  logic float_bit;

  initial begin
    spi_enable = 1'b0;
    spi_clk = 1'b0;
    drive_on = 1'b0;
    drive_bit = 1'b0;
    float_bit = 1'b0;
  end

  // undriven pin toggles so a stale level never passes for data
  always @(posedge clk_sys) float_bit <= ~float_bit;
  always_comb spi_data_in = spi_data_oe ? spi_data_out :
                            (drive_on ? drive_bit : float_bit);

  // ---------------------------------------------------------------
  // one serial frame: n bits out msb first, then nrd bits back
  // ---------------------------------------------------------------
  // spi_enable frames the run: raised after the first cycle, dropped three cycles before the end
  task automatic frame(input logic [16:0] bits, input int n,
                       input int nrd, output logic [11:0] rd);
    rd = 12'h000;
    @(posedge clk_sys);
    spi_enable <= 1'b1;
    drive_on <= 1'b1;
    repeat (2) @(posedge clk_sys);
    for (int i = 0; i < n; i++) begin
      drive_bit <= bits[16-i];
      repeat (2) @(posedge clk_sys);
      spi_clk <= 1'b1;
      repeat (2) @(posedge clk_sys);
      spi_clk <= 1'b0;
    end
    drive_on <= 1'b0;
    for (int i = 0; i < nrd; i++) begin
      // long low phase: device answers a cycle or two after the fall
      repeat (4) @(posedge clk_sys);
      rd = {rd[10:0], spi_data_in};
      spi_clk <= 1'b1;
      repeat (2) @(posedge clk_sys);
      spi_clk <= 1'b0;
    end
    repeat (2) @(posedge clk_sys);
    spi_enable <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask
endmodule // ssc_ctl_model

// file: verification/test_sensor_sequencer_config_regs.sv
`timescale 1ns/1ps
module test_sensor_sequencer_config_regs
  import ssc_pkg::*;
;
  logic clk_sys, rst, seq_reset_n, spi_enable, spi_clk, spi_data_in;
  logic spi_data_out, spi_data_oe, seq_clk, master_mode, subsample_y;
  logic analog_out_on, line_calib, second_slope_on, third_slope_on;
  logic reverse_x, reverse_y, nondestructive;
  logic [2:0] int_time_oe;
  logic [1:0] clk_range;
  logic [7:0] column_start, kernel_count, calibration_level_code;
  logic [7:0] black_level_code, offset_level_code;
  logic [8:0] row_start;
  logic [11:0] reset_pulse_lines, dual_slope_position;
  logic [11:0] triple_slope_position, transfer_position;
  logic [11:0] converter_path_select, amplifier_settings;
  logic [32:0] converter_trim;
  logic [11:0] exp_r [16];
  logic [11:0] d;
  logic [11:0] x;
  logic [7:0] s;
  int num_errors, compares, seed;

  ssc_config_regs ssc_config_regs_inst (.clk_sys(clk_sys), .rst(rst),
    .seq_reset_n(seq_reset_n), .spi_enable(spi_enable), .spi_clk(spi_clk),
    .spi_data_in(spi_data_in), .spi_data_out(spi_data_out),
    .spi_data_oe(spi_data_oe), .seq_clk(seq_clk), .int_time_oe(int_time_oe),
    .master_mode(master_mode), .subsample_y(subsample_y),
    .clk_range(clk_range), .analog_out_on(analog_out_on),
    .line_calib(line_calib), .second_slope_on(second_slope_on),
    .third_slope_on(third_slope_on), .reverse_x(reverse_x),
    .reverse_y(reverse_y), .nondestructive(nondestructive),
    .column_start(column_start), .row_start(row_start),
    .kernel_count(kernel_count), .reset_pulse_lines(reset_pulse_lines),
    .dual_slope_position(dual_slope_position),
    .triple_slope_position(triple_slope_position),
    .transfer_position(transfer_position),
    .calibration_level_code(calibration_level_code),
    .black_level_code(black_level_code),
    .offset_level_code(offset_level_code),
    .converter_path_select(converter_path_select),
    .amplifier_settings(amplifier_settings),
    .converter_trim(converter_trim));
  ssc_ctl_model ssc_ctl_model_inst (.clk_sys(clk_sys),
    .spi_data_out(spi_data_out), .spi_data_oe(spi_data_oe),
    .spi_enable(spi_enable), .spi_clk(spi_clk), .spi_data_in(spi_data_in));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [11:0] out_of(input int a);
    case (a)
      0: return {1'b0, nondestructive, reverse_y, reverse_x, third_slope_on,
        second_slope_on, line_calib, analog_out_on, clk_range, subsample_y,
        master_mode};
      1: return {4'h0, column_start};
      2: return {3'h0, row_start};
      3: return {4'h0, kernel_count};
      4: return reset_pulse_lines;
      5: return dual_slope_position;
      6: return triple_slope_position;
      7: return transfer_position;
      8: return {4'h0, calibration_level_code};
      9: return {4'h0, black_level_code};
      10: return {4'h0, offset_level_code};
      11: return converter_path_select;
      12: return amplifier_settings;
      13: return converter_trim[11:0];
      14: return converter_trim[23:12];
      default: return {3'h0, converter_trim[32:24]};
    endcase
  endfunction

  // expected contents after a write, refusals included
  function automatic void upd(input int a, input logic [11:0] v);
    if (a == 1 && v > 12'h04F) return;
    if (a == 0 && seq_reset_n) v = {v[11:4], exp_r[0][3:2], v[1], exp_r[0][0]};
    exp_r[a] = v & SSC_REG_MASK[a];
  endfunction

  task automatic chk(input logic [11:0] got, input logic [11:0] e);
    compares++;
    if (got !== e) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, e);
    end
  endtask

  task automatic wr(input int a, input logic [11:0] v);
    ssc_ctl_model_inst.frame({1'b1, 4'(a), v}, 17, 0, x);
    upd(a, v);
  endtask

  task automatic chk_all();
    for (int a = 0; a < 16; a++) begin
      chk(out_of(a), exp_r[a]);
      ssc_ctl_model_inst.frame({1'b0, 4'(a), 12'h000}, 5, 12, x);
      chk(x, exp_r[a]);
    end
  endtask

  task automatic test_done();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk_sys);
    num_errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    test_done();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    seed = 32'h5143CE59;
    rst = 1'b1;
    seq_reset_n = 1'b1;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    for (int a = 0; a < 16; a++) exp_r[a] = SSC_RESET_VAL[a];
    chk_all();
    $display("test reset_values done");
    // master and range only move under sequencer reset
    seq_reset_n <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 12'h7FF : (i == 1) ? 12'h000 : 12'($random(seed));
      d[3:2] = 2'(i);
      wr(0, d);
      chk(out_of(0), exp_r[0]);
      chk({9'h000, int_time_oe}, {9'h000, {3{exp_r[0][0]}}});
    end
    seq_reset_n <= 1'b1;
    @(posedge clk_sys);
    wr(0, ~exp_r[0]);
    chk(out_of(0), exp_r[0]);
    $display("test timing_control done");
    for (int r = 0; r < 3; r++) begin
      for (int a = 1; a < 16; a++) begin
        d = 12'($random(seed));
        if (a == 1) d = (r == 0) ? 12'h04F : (r == 1) ? 12'h050 : {4'h0, d[7:0]};
        wr(a, d);
        chk(out_of(a), exp_r[a]);
      end
    end
    chk_all();
    $display("test random_writes done");
    // a short frame must not commit
    ssc_ctl_model_inst.frame({1'b1, 4'h4, 12'h5A5}, 16, 0, x);
    chk(out_of(4), exp_r[4]);
    $display("test short_frame done");
    seq_reset_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    seq_reset_n <= 1'b1;
    for (int a = 0; a < 16; a++) exp_r[a] = SSC_RESET_VAL[a];
    chk_all();
    $display("test sequencer_reset done");
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      #1 s[i] = seq_clk;
    end
    for (int i = 0; i < 4; i++) begin
      chk({11'h000, s[i+2]}, {11'h000, ~s[i]});
      chk({11'h000, s[i+4]}, {11'h000, s[i]});
    end
    $display("test sequencer_clock done");
    test_done();
  end
endmodule // test_sensor_sequencer_config_regs
